// ---- core/ism_mode_ctrl.sv ----
`timescale 1ns/1ps
module ism_mode_ctrl (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         sys_rst,
   // converter sample stream
   input  wire logic                         conv_valid,
   input  wire logic [ism_pkg::CH_W-1:0]     conv_chan,
   input  wire logic [ism_pkg::RAW_W-1:0]    conv_raw,
   // serial control port
   input  wire logic                         scl_pin,
   input  wire logic                         sda_rx,
   output logic                              sda_tx,
   output logic                              sda_oe,
   // power mode strap
   input  wire logic                         low_power_select_pin,
   // host alert, open drain
   output logic                              host_alert_pin,
   output logic                              host_alert_pin_oe,
   // button outputs, push-pull
   output logic [ism_pkg::NUM_CH-1:0]        button_press_pins
);
   import ism_pkg::*;

   logic [2:0]        pins_flt;
   logic              scl_f, sda_f, lp_f;
   logic              scl_q, sda_q;
   logic              scl_rise, scl_fall, start_det, stop_det;
   ism_i2c_st_t       state_q, state_d;
   logic [3:0]        cnt_q, cnt_d;
   logic [7:0]        shift_q, shift_d, tx_q, tx_d, ptr_q, ptr_d;
   logic              rw_q, rw_d, drv_q, drv_d, nack_q, nack_d;
   logic              wr_stb, load_tx, st_rd;
   logic [7:0]        rd_data;
   logic [7:0]        ctrl_q, thr_q, alg_q;
   logic [NUM_CH-1:0] pol_q;
   logic              btn_mode, alert_pol;
   logic [NUM_CH-1:0] press_q, press_prev_q;
   logic              btn_evt, rdy_q, evt_q, alert_q, alert_d, oe_q;
   logic [7:0]        snap_out_q;
   logic [DATA_W-1:0] data_q    [NUM_CH];
   logic [RAW_W-1:0]  raw_q     [NUM_CH];
   logic [DATA_W-1:0] snap_data [NUM_CH];
   logic [RAW_W-1:0]  snap_raw  [NUM_CH];
   logic [GAIN_W-1:0] gain_q    [NUM_CH];

   // both serial lines and the strap pass the sync and spike filter
   ism_pin_filter #(.WIDTH(3)) u_filt (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pins    ({low_power_select_pin, sda_rx, scl_pin}),
      .levels  (pins_flt)
   );
   assign scl_f = pins_flt[0];
   assign sda_f = pins_flt[1];
   assign lp_f  = pins_flt[2];

   // bus conditions from filtered levels
   assign scl_rise  = scl_f & ~scl_q;
   assign scl_fall  = ~scl_f & scl_q;
   assign start_det = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;

   // byte engine: shift on rising clock, act on falling clock
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      drv_d   = drv_q;
      nack_d  = nack_q;
      wr_stb  = 1'b0;
      load_tx = 1'b0;
      if (stop_det) begin
         state_d = ST_IDLE;
         drv_d   = 1'b0;
      end else if (start_det) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         drv_d   = 1'b0;
      end else if (scl_rise) begin
         if (state_q inside {ST_ADDR, ST_PTR, ST_WDATA}) begin
            shift_d = {shift_q[6:0], sda_f};
            cnt_d   = cnt_q + 4'h1;
         end
         if (state_q == ST_RACK) begin
            nack_d = sda_f;
         end
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (cnt_q == BYTE_BITS) begin
                  if (shift_q[7:1] == TARGET_ADDR) begin
                     state_d = ST_ADDR_ACK;
                     rw_d    = shift_q[0];
                     drv_d   = 1'b1;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (rw_q) begin
                  load_tx = 1'b1;
               end else begin
                  drv_d   = 1'b0;
                  cnt_d   = 4'h0;
                  state_d = ST_PTR;
               end
            end
            ST_PTR: begin
               if (cnt_q == BYTE_BITS) begin
                  ptr_d   = shift_q;
                  drv_d   = 1'b1;
                  state_d = ST_PTR_ACK;
               end
            end
            ST_PTR_ACK, ST_WACK: begin
               drv_d   = 1'b0;
               cnt_d   = 4'h0;
               state_d = ST_WDATA;
            end
            ST_WDATA: begin
               if (cnt_q == BYTE_BITS) begin
                  wr_stb  = 1'b1;
                  ptr_d   = ptr_q + 8'h01;
                  drv_d   = 1'b1;
                  state_d = ST_WACK;
               end
            end
            ST_RDATA: begin
               if (cnt_q == BYTE_BITS) begin
                  drv_d   = 1'b0;
                  state_d = ST_RACK;
               end else begin
                  tx_d  = {tx_q[6:0], 1'b0};
                  drv_d = ~tx_q[6];
                  cnt_d = cnt_q + 4'h1;
               end
            end
            ST_RACK: begin
               if (nack_q) begin
                  state_d = ST_IDLE;
               end else begin
                  load_tx = 1'b1;
               end
            end
            default: state_d = ST_IDLE;
         endcase
         // read byte load, pointer auto-increments
         if (load_tx) begin
            tx_d    = rd_data;
            drv_d   = ~rd_data[7];
            cnt_d   = 4'h1;
            ptr_d   = ptr_q + 8'h01;
            state_d = ST_RDATA;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         rw_q    <= 1'b0;
         drv_q   <= 1'b0;
         nack_q  <= 1'b0;
      end else begin
         scl_q   <= scl_f;
         sda_q   <= sda_f;
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         drv_q   <= drv_d;
         nack_q  <= nack_d;
      end
   end

   // the target only ever pulls the data line low
   assign sda_tx = 1'b0;
   assign sda_oe = drv_q;
   // status fetch is the clear and freeze point
   assign st_rd  = load_tx && (ptr_q == REG_STATUS);

   // control registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
         thr_q  <= THR_RST;
         alg_q  <= ALG_RST;
         pol_q  <= POL_RST;
      end else if (wr_stb) begin
         if (ptr_q == REG_CTRL) ctrl_q <= shift_q;
         if (ptr_q == REG_THR)  thr_q  <= shift_q;
         if (ptr_q == REG_ALG)  alg_q  <= shift_q;
         if (ptr_q == REG_POL)  pol_q  <= shift_q[NUM_CH-1:0];
      end
   end
   assign btn_mode  = ctrl_q[CTRL_ALG_BIT] != ALG_MODE_RAW;
   assign alert_pol = ctrl_q[CTRL_APOL_BIT];

   // per channel: raw capture, tracking, gain, threshold, pin
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic                     hit, base_ok_q, press_d, veto;
      logic [RAW_W-1:0]         base_q, base_d;
      logic signed [RAW_W:0]    diff, step;
      logic [GAIN_W:0]          gain_p1;
      logic signed [32:0]       scaled;
      logic [DATA_W-1:0]        data_d;
      logic signed [DATA_W-1:0] thr_s;

      assign hit     = conv_valid && (conv_chan == CH_W'(ch));
      assign diff    = $signed({1'b0, conv_raw}) - $signed({1'b0, base_q});
      assign gain_p1 = {1'b0, gain_q[ch]} + 7'h01;
      // gain scales the deflection, so data tracks force
      assign scaled  = (diff * $signed({1'b0, gain_p1})) >>> GAIN_SHIFT;
      assign data_d  = (scaled > SAT_HI) ? DATA_HI :
                       (scaled < SAT_LO) ? DATA_LO :
                       scaled[DATA_W-1:0];
      assign thr_s   = $signed({4'h0, thr_q});
      // an opposite swing on the neighbour hints at crosstalk
      assign veto    = alg_q[ALG_XT_BIT] &&
                       ($signed(data_q[ch ^ 1]) <= -thr_s);
      assign press_d = ($signed(data_d) >= thr_s) && !veto;
      // slow drift follow, rate set by shift field
      assign step    = diff >>> alg_q[2:0];
      assign base_d  = base_q + step[RAW_W-1:0];

      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            gain_q[ch] <= GAIN_RST;
         end else if (wr_stb && ptr_q == REG_GAIN0 + 8'(2 * ch)) begin
            gain_q[ch] <= shift_q[GAIN_W-1:0];
         end
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            raw_q[ch]   <= '0;
            base_q      <= '0;
            base_ok_q   <= 1'b0;
            data_q[ch]  <= '0;
            press_q[ch] <= 1'b0;
         end else begin
            if (hit) raw_q[ch] <= conv_raw;
            if (!btn_mode) begin
               base_ok_q   <= 1'b0;
               press_q[ch] <= 1'b0;
            end else if (hit && !base_ok_q) begin
               base_q    <= conv_raw;
               base_ok_q <= 1'b1;
            end else if (hit) begin
               data_q[ch]  <= data_d;
               press_q[ch] <= press_d;
               if (!press_d) base_q <= base_d;
            end
         end
      end

      // frozen copies served to the host after a status read
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            snap_raw[ch]  <= '0;
            snap_data[ch] <= '0;
         end else if (st_rd) begin
            snap_raw[ch]  <= raw_q[ch];
            snap_data[ch] <= data_q[ch];
         end
      end

      // registered pin, inactive level when no press decided
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            button_press_pins[ch] <= ~POL_RST[ch];
         end else begin
            button_press_pins[ch] <= pol_q[ch] ? press_q[ch]
                                               : ~press_q[ch];
         end
      end
   end

   // sticky flags; an event in the clear cycle wins
   assign btn_evt = press_q != press_prev_q;
   assign alert_d = (btn_mode ? btn_evt : conv_valid) |
                    (alert_q & ~st_rd);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         press_prev_q <= '0;
         rdy_q        <= 1'b0;
         evt_q        <= 1'b0;
         alert_q      <= 1'b0;
         oe_q         <= 1'b0;
         snap_out_q   <= 8'h00;
      end else begin
         press_prev_q <= press_q;
         rdy_q        <= conv_valid | (rdy_q & ~st_rd);
         evt_q        <= btn_evt | (evt_q & ~st_rd);
         alert_q      <= alert_d;
         oe_q         <= alert_d ^ alert_pol;
         if (st_rd) snap_out_q <= {rdy_q, 3'h0, press_q};
      end
   end
   // active-low alert pulls the pin; active-high pulls when idle
   assign host_alert_pin    = 1'b0;
   assign host_alert_pin_oe = oe_q;

   // read mux, unmapped offsets read zero
   always_comb begin
      rd_data = 8'h00;
      case (ptr_q)
         REG_STATUS: rd_data = {4'h0, btn_mode, lp_f, evt_q, rdy_q};
         REG_OUT:    rd_data = snap_out_q;
         REG_CTRL:   rd_data = ctrl_q;
         REG_THR:    rd_data = thr_q;
         REG_ALG:    rd_data = alg_q;
         REG_POL:    rd_data = {4'h0, pol_q};
         default:    rd_data = 8'h00;
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
         if (ptr_q == REG_DATA0 + 8'(2 * c))
            rd_data = snap_data[c][7:0];
         if (ptr_q == REG_DATA0 + 8'(2 * c + 1))
            rd_data = {{4{snap_data[c][DATA_W-1]}}, snap_data[c][11:8]};
         if (ptr_q == REG_GAIN0 + 8'(2 * c))
            rd_data = {2'h0, gain_q[c]};
         if (ptr_q == REG_RAW0 + 8'(3 * c))
            rd_data = snap_raw[c][23:16];
         if (ptr_q == REG_RAW0 + 8'(3 * c + 1))
            rd_data = snap_raw[c][15:8];
         if (ptr_q == REG_RAW0 + 8'(3 * c + 2))
            rd_data = snap_raw[c][7:0];
      end
   end

endmodule

// ---- include/ism_pkg.sv ----
package ism_pkg;

   // channel and data widths
   localparam int NUM_CH = 4;
   localparam int CH_W   = 2;
   localparam int RAW_W  = 24;
   localparam int DATA_W = 12;
   localparam int GAIN_W = 6;

   // clock and serial port timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SPIKE_NS      = 50;
   localparam int SCL_MAX_KHZ   = 400;
   // spike may cover this many samples; one more is needed to accept
   localparam int FILT_SPAN        = SPIKE_NS / CLK_PERIOD_NS + 1;
   localparam logic [1:0] FILT_CYC = 2'(FILT_SPAN);

   // serial target port
   localparam logic [6:0] TARGET_ADDR = 7'h2A;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // register offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_OUT    = 8'h01;
   localparam logic [7:0] REG_DATA0  = 8'h02;
   localparam logic [7:0] REG_GAIN0  = 8'h0E;
   localparam logic [7:0] REG_CTRL   = 8'h11;
   localparam logic [7:0] REG_THR    = 8'h15;
   localparam logic [7:0] REG_ALG    = 8'h16;
   localparam logic [7:0] REG_POL    = 8'h1C;
   localparam logic [7:0] REG_RAW0   = 8'h30;

   // field positions
   localparam int CTRL_ALG_BIT  = 7;
   localparam int CTRL_APOL_BIT = 6;
   localparam int ALG_XT_BIT    = 3;
   localparam int OUT_RDY_BIT   = 7;
   localparam logic ALG_MODE_RAW = 1'b0;

   // reset values
   localparam logic [7:0]        CTRL_RST = 8'h80;
   localparam logic [7:0]        THR_RST  = 8'h40;
   localparam logic [7:0]        ALG_RST  = 8'h04;
   localparam logic [NUM_CH-1:0] POL_RST  = 4'hF;
   localparam logic [GAIN_W-1:0] GAIN_RST = 6'h00;

   // processing scale and saturation bounds
   localparam int GAIN_SHIFT = 4;
   localparam logic signed [32:0] SAT_HI = 33'sh0_0000_07FF;
   localparam logic signed [32:0] SAT_LO = 33'sh1_FFFF_F800;
   localparam logic [DATA_W-1:0]  DATA_HI = 12'h7FF;
   localparam logic [DATA_W-1:0]  DATA_LO = 12'h800;

   // serial port receiver states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } ism_i2c_st_t;

endpackage

// ---- core/ism_pin_filter.sv ----
`timescale 1ns/1ps
module ism_pin_filter #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pins,
   output logic      [WIDTH-1:0] levels
);
   import ism_pkg::*;

   // per pin: two-flop sync, then a stability counter
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      logic       meta_q;
      logic       sync_q;
      logic [1:0] cnt_q;
      logic [1:0] cnt_d;
      logic       lvl_q;
      logic       differs;
      logic       accept;

      assign differs = sync_q != lvl_q;
      // a spike shorter than the span never reaches the count
      assign accept  = differs && (cnt_q == FILT_CYC);
      assign cnt_d   = differs ? cnt_q + 2'h1 : 2'h0;

      // lines idle high, so filtered levels start high
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            cnt_q  <= 2'h0;
            lvl_q  <= 1'b1;
         end else begin
            meta_q <= pins[i];
            sync_q <= meta_q;
            cnt_q  <= accept ? 2'h0 : cnt_d;
            lvl_q  <= accept ? sync_q : lvl_q;
         end
      end

      assign levels[i] = lvl_q;
   end

endmodule

// ---- verification/ism_mode_ctrl_assertions.sv ----
`timescale 1ns/1ps
module ism_mode_ctrl_chk (
   // clock and reset
   input wire logic                        sys_clk,
   input wire logic                        sys_rst,
   // converter samples
   input wire logic                        conv_valid,
   input wire logic [ism_pkg::CH_W-1:0]    conv_chan,
   input wire logic [ism_pkg::RAW_W-1:0]   conv_raw,
   // serial port
   input wire logic                        scl_pin,
   input wire logic                        sda_rx,
   input wire logic                        sda_tx,
   input wire logic                        sda_oe,
   // strap, alert and buttons
   input wire logic                        low_power_select_pin,
   input wire logic                        host_alert_pin,
   input wire logic                        host_alert_pin_oe,
   input wire logic [ism_pkg::NUM_CH-1:0]  button_press_pins
);
   import ism_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // scl held low long after its fall: the answer must be settled by then
   sequence s_ans_due;
      $fell(scl_pin) ##45 (!scl_pin) [*8];
   endsequence

   // open-drain value outputs only ever pull low
   AST_SDA_VALUE_LOW: assert property (sda_tx == 1'b0)
      else $error("data drive value not low");
   AST_ALERT_VALUE_LOW: assert property (host_alert_pin == 1'b0)
      else $error("alert drive value not low");
   // data may only move while the clock is low, else a false start or stop
   AST_SDA_STILL_SCL_HIGH: assert property ($changed(sda_oe) |-> !scl_pin)
      else $error("data drive changed with clock high");
   AST_ACK_AFTER_FILTER: assert property ($rose(sda_oe) |-> !$past(scl_pin, 4))
      else $error("data drive before filtered clock fall");
   AST_ANSWER_SETTLED: assert property (s_ans_due |-> $stable(sda_oe))
      else $error("data drive moved late in clock low");
   // alert and pins move only after a sample or a register access
   AST_ALERT_CAUSE: assert property ($rose(host_alert_pin_oe) |->
      $past(conv_valid, 1) || $past(conv_valid, 2) || $past(conv_valid, 3)
      || sda_oe)
      else $error("alert raised without a sample");
   AST_ALERT_CLEAR: assert property ($fell(host_alert_pin_oe) |-> !scl_pin)
      else $error("alert cleared outside a status fetch");
   AST_PINS_CAUSE: assert property ($changed(button_press_pins) |->
      $past(conv_valid, 1) || $past(conv_valid, 2) || $past(conv_valid, 3)
      || sda_oe)
      else $error("button pins moved without a cause");
endmodule

// ---- verification/ism_i2c_host.sv ----
`timescale 1ns/1ps
// host controller model; data line has a pull-up, host only pulls low
module ism_i2c_host #(
   parameter int T_LOW  = 65,
   parameter int T_HIGH = 60
) (
   // clock
   input  wire logic sys_clk,
   // bus lines
   output logic      scl_pin,
   output logic      sda_low,
   input  wire logic sda_line
);
   logic glitch = 1'b0;
   initial begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one bit, 125 cycles: data moves mid-low, far from the filtered edge
   task automatic bit_io(input logic v, output logic s);
      tick(T_LOW/2);
      sda_low <= ~v;
      tick(T_LOW - T_LOW/2);
      scl_pin <= 1'b1;
      tick(T_HIGH/2);
      // three samples wide: the longest spike the filter must swallow
      if (glitch) begin
         scl_pin <= 1'b0;
         tick(3);
         scl_pin <= 1'b1;
         sda_low <= v;
         tick(3);
         sda_low <= ~v;
      end
      tick(T_HIGH - T_HIGH/2 - (glitch ? 6 : 0));
      s = sda_line;
      scl_pin <= 1'b0;
   endtask
   // start or repeated start, from either clock level
   task automatic start();
      tick(T_LOW/2);
      sda_low <= 1'b0;
      tick(T_LOW/2);
      scl_pin <= 1'b1;
      tick(T_HIGH);
      sda_low <= 1'b1;
      tick(T_HIGH);
      scl_pin <= 1'b0;
   endtask
   task automatic stop();
      tick(T_LOW/2);
      sda_low <= 1'b1;
      tick(T_LOW/2);
      scl_pin <= 1'b1;
      tick(T_HIGH);
      sda_low <= 1'b0;
      tick(2*T_LOW);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic get(output logic [7:0] b, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, s);
   endtask
endmodule

// ---- verification/test_inductive_sensing_mode_control.sv ----
`timescale 1ns/1ps
module test_inductive_sensing_mode_control;
   import ism_pkg::*;
   logic              sys_clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              conv_valid = 1'b0;
   logic [CH_W-1:0]   conv_chan = 2'h0;
   logic [RAW_W-1:0]  conv_raw = 24'h0;
   logic              lp_pin = 1'b1;
   logic              scl_pin, sda_low, sda_rx, sda_tx, sda_oe;
   logic              alert, alert_oe;
   logic [NUM_CH-1:0] pins;
   logic [7:0]        rb [8];
   int                n_mismatch = 0;
   int                check_count = 0;
   int                cyc = 0;

   // pull-up: the line is low while either side pulls
   assign sda_rx = ~(sda_low | sda_oe);
   always #10 sys_clk = ~sys_clk;

   ism_mode_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_raw(conv_raw),
      .scl_pin(scl_pin), .sda_rx(sda_rx), .sda_tx(sda_tx), .sda_oe(sda_oe),
      .low_power_select_pin(lp_pin), .host_alert_pin(alert),
      .host_alert_pin_oe(alert_oe), .button_press_pins(pins));
   ism_i2c_host i_host (.sys_clk(sys_clk), .scl_pin(scl_pin),
      .sda_low(sda_low), .sda_line(sda_rx));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic a0, a1, a2;
      i_host.start();
      i_host.put({TARGET_ADDR, 1'b0}, a0);
      i_host.put(ptr, a1);
      i_host.put(d, a2);
      i_host.stop();
      check({5'h0, a0, a1, a2}, 8'h07);
   endtask
   // burst read; the last byte gets no acknowledge
   task automatic rd(input logic [7:0] ptr, input int n);
      logic a0, a1, a2;
      i_host.start();
      i_host.put({TARGET_ADDR, 1'b0}, a0);
      i_host.put(ptr, a1);
      i_host.start();
      i_host.put({TARGET_ADDR, 1'b1}, a2);
      for (int i = 0; i < n; i++) i_host.get(rb[i], i == n - 1);
      i_host.stop();
      check({5'h0, a0, a1, a2}, 8'h07);
   endtask
   task automatic sample(input logic [1:0] ch, input logic [23:0] raw);
      @(posedge sys_clk);
      conv_valid <= 1'b1;
      conv_chan <= ch;
      conv_raw <= raw;
      @(posedge sys_clk);
      conv_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic t_reset();
      check({4'h0, pins}, 8'h00);
      rd(REG_CTRL, 2);
      check(rb[0], CTRL_RST);
      check(rb[1], {2'h0, GAIN_RST});
      rd(8'h40, 1);
      check(rb[0], 8'h00);
   endtask
   task automatic t_raw();
      lp_pin <= 1'b0;
      wr(REG_CTRL, 8'h00);
      sample(2'h1, 24'hA5C35A);
      check({7'h0, alert_oe}, 8'h01);
      check({4'h0, pins}, 8'h00);
      rd(REG_STATUS, 2);
      check({7'h0, alert_oe}, 8'h00);
      check(rb[0], 8'h01);
      check(rb[1], 8'h80);
      rd(8'h33, 3);
      check(rb[0], 8'hA5);
      check(rb[1], 8'hC3);
      check(rb[2], 8'h5A);
   endtask
   // presses, force, per-channel gain, polarity, glitches on the gain write
   task automatic t_button();
      lp_pin <= 1'b1;
      wr(REG_CTRL, 8'h80);
      i_host.glitch = 1'b1;
      wr(REG_GAIN0, 8'h0F);
      i_host.glitch = 1'b0;
      sample(2'h0, 24'h001000);
      sample(2'h1, 24'h002000);
      check({4'h0, pins}, 8'h00);
      sample(2'h0, 24'h001050);
      sample(2'h1, 24'h002500);
      check({4'h0, pins}, 8'h03);
      check({7'h0, alert_oe}, 8'h01);
      rd(REG_STATUS, 6);
      check(rb[0] & 8'hFE, 8'h0E);
      check(rb[1] & 8'h0F, 8'h03);
      check(rb[2], 8'h50);
      check(rb[3], 8'h00);
      check(rb[4], 8'h50);
      check(rb[5], 8'h00);
      rd(REG_RAW0, 3);
      check(rb[1], 8'h10);
      check(rb[2], 8'h50);
      sample(2'h0, 24'h001070);
      rd(REG_STATUS, 4);
      check({7'h0, rb[2] > 8'h50}, 8'h01);
      wr(REG_POL, 8'h0E);
      check({4'h0, pins}, 8'h02);
      sample(2'h0, 24'h001000);
      check({4'h0, pins}, 8'h03);
      wr(REG_CTRL, 8'h00);
      check({4'h0, pins}, 8'h01);
   endtask
   // crosstalk veto and active-high alert, both unused before here
   task automatic t_veto();
      wr(REG_ALG, 8'h0C);
      wr(REG_CTRL, 8'hC0);
      check({7'h0, alert_oe}, 8'h00);
      sample(2'h0, 24'h001000);
      sample(2'h1, 24'h002000);
      sample(2'h1, 24'h001000);
      sample(2'h0, 24'h001050);
      check({4'h0, pins}, 8'h01);
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      t_reset();
      t_raw();
      t_button();
      t_veto();
      end_of_test();
   end
endmodule

bind ism_mode_ctrl ism_mode_ctrl_chk i_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .conv_valid(conv_valid), .conv_chan(conv_chan),
   .conv_raw(conv_raw), .scl_pin(scl_pin), .sda_rx(sda_rx),
   .sda_tx(sda_tx), .sda_oe(sda_oe),
   .low_power_select_pin(low_power_select_pin),
   .host_alert_pin(host_alert_pin), .host_alert_pin_oe(host_alert_pin_oe),
   .button_press_pins(button_press_pins));
